// [src/flash_host_consts.svh]
// Purpose: timing and width constants for the flash host controller
// Assumes: 20 MHz clock, 50 ns period
// Notes:   access times are plain defaults, adjust per part grade
`ifndef FLASH_HOST_CONSTS_SVH
`define FLASH_HOST_CONSTS_SVH
`define CLK_PERIOD_NS        50
`define ADDR_W               26
`define DATA_W               16
`define PAGE_BITS            4
`define RESET_PULSE_NS       200
`define RESET_HOLD_NS        50000
`define ADDRESS_ACCESS_NS    100
`define SELECT_ACCESS_NS     100
`define OUTPUT_DRIVE_NS      25
`define PAGE_ACCESS_NS       25
`define WRITE_PULSE_NS       50
`define WRITE_HIGH_NS        50
// least times round up to whole cycles
`define CYC_UP(ns) (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RESET_PULSE_CYC      `CYC_UP(`RESET_PULSE_NS)
`define RESET_HOLD_CYC       `CYC_UP(`RESET_HOLD_NS)
`define RANDOM_ACCESS_NS ((`ADDRESS_ACCESS_NS > `SELECT_ACCESS_NS) ? \
                          `ADDRESS_ACCESS_NS : `SELECT_ACCESS_NS)
`define RANDOM_CYC           `CYC_UP(`RANDOM_ACCESS_NS)
`define PAGE_CYC             `CYC_UP(`PAGE_ACCESS_NS)
`define OE_CYC               `CYC_UP(`OUTPUT_DRIVE_NS)
`define WRITE_PULSE_CYC      `CYC_UP(`WRITE_PULSE_NS)
`define WRITE_HIGH_CYC       `CYC_UP(`WRITE_HIGH_NS)
`define CNT_W                16
`endif

// [src/flash_host_pkg.sv]
// Purpose: types for the flash host controller
// Assumes: nothing beyond the constants header
// Notes:   states only
package flash_host_pkg;
  typedef enum logic [2:0] {
    ST_RESET,
    ST_RESET_HOLD,
    ST_IDLE,
    ST_READ_SETUP,
    ST_READ_WAIT,
    ST_WRITE_LOW,
    ST_WRITE_HIGH
  } host_state_t;
endpackage : flash_host_pkg

// [src/flash_host_ctrl.sv]
// Purpose: host controller driving a parallel nor flash pin interface
// Assumes: pins sampled as synchronous to i_mclk; one request at a time
// Notes:   reads hold select low and reuse the open page when possible
`timescale 1ns/10ps
`include "flash_host_consts.svh"
module flash_host_ctrl
  import flash_host_pkg::*;
(
  input  wire logic               i_mclk,
  input  wire logic               i_reset,
  input  wire logic               i_req,
  input  wire logic               i_write,
  input  wire logic               i_flash_reset,
  input  wire logic [`ADDR_W-1:0] i_addr,
  input  wire logic [`DATA_W-1:0] i_wdata,
  input  wire logic [`DATA_W-1:0] i_dq,
  input  wire logic               i_ready_busy_n,
  output logic                    o_ready,
  output logic                    o_rvalid,
  output logic [`DATA_W-1:0]      o_rdata,
  output logic                    o_reset_n,
  output logic                    o_ce_n,
  output logic                    o_oe_n,
  output logic                    o_we_n,
  output logic [`ADDR_W-1:0]      o_address_lines,
  output logic [`DATA_W-1:0]      o_data_lines,
  output logic                    o_data_lines_oe
);
  host_state_t            state;
  logic [`CNT_W-1:0]      cnt;
  logic                   page_open;
  logic                   page_hit;
  logic                   take;
  logic [`CNT_W-1:0]      wait_cyc;
  logic [`CNT_W-1:0]      wait_cyc_hold;

  // assertions below share this clock and reset
  default clocking main_cb @(posedge i_mclk);
  endclocking
  default disable iff (i_reset);

  // busy device refuses new work
  assign o_ready  = (state == ST_IDLE) && i_ready_busy_n;
  assign take     = o_ready && i_req;
  assign page_hit = page_open && !i_write && !o_ce_n &&
                    (i_addr[`ADDR_W-1:`PAGE_BITS] ==
                     o_address_lines[`ADDR_W-1:`PAGE_BITS]) &&
                    (i_addr[`PAGE_BITS-1:0] !=
                     o_address_lines[`PAGE_BITS-1:0]);
  assign wait_cyc = page_hit ? `CNT_W'(`PAGE_CYC) : `CNT_W'(`RANDOM_CYC);

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      state <= ST_RESET;
      cnt   <= '0;
    end else if (i_flash_reset && state != ST_RESET) begin
      state <= ST_RESET;  // aborts transfer; caller resends
      cnt   <= '0;
    end else begin
      unique case (state)
        ST_RESET: begin
          cnt <= cnt + `CNT_W'(1);
          if (cnt >= `CNT_W'(`RESET_PULSE_CYC - 1)) begin
            state <= ST_RESET_HOLD;
            cnt   <= '0;
          end
        end
        ST_RESET_HOLD: begin
          cnt <= cnt + `CNT_W'(1);
          if (cnt >= `CNT_W'(`RESET_HOLD_CYC - 1)) begin
            state <= ST_IDLE;
            cnt   <= '0;
          end
        end
        ST_IDLE: begin
          cnt <= '0;
          if (take && i_write)
            state <= ST_WRITE_LOW;
          else if (take && page_hit)
            state <= ST_READ_WAIT;
          else if (take)
            state <= ST_READ_SETUP;
        end
        ST_READ_SETUP: begin
          state <= ST_READ_WAIT;
          cnt   <= '0;
        end
        ST_READ_WAIT: begin
          cnt <= cnt + `CNT_W'(1);
          if (cnt >= wait_cyc_hold)
            state <= ST_IDLE;
        end
        ST_WRITE_LOW: begin
          cnt <= cnt + `CNT_W'(1);
          if (cnt >= `CNT_W'(`WRITE_PULSE_CYC - 1)) begin
            state <= ST_WRITE_HIGH;
            cnt   <= '0;
          end
        end
        ST_WRITE_HIGH: begin
          cnt <= cnt + `CNT_W'(1);
          // one extra cycle so select rises after the strobe
          if (cnt >= `CNT_W'(`WRITE_HIGH_CYC))
            state <= ST_IDLE;
        end
      endcase
    end
  end

  // wait length frozen when the read is taken
  always_ff @(posedge i_mclk) begin
    if (i_reset)
      wait_cyc_hold <= `CNT_W'(`RANDOM_CYC);
    else if (take)
      wait_cyc_hold <= wait_cyc - `CNT_W'(1);
  end

  // pin drive
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      o_reset_n <= 1'b0;
      o_ce_n    <= 1'b1;
      o_oe_n    <= 1'b1;
      o_we_n    <= 1'b1;
      page_open <= 1'b0;
    end else begin
      o_reset_n <= !(state == ST_RESET || i_flash_reset);
      if (state == ST_RESET || i_flash_reset) begin
        o_ce_n    <= 1'b1;
        o_oe_n    <= 1'b1;
        o_we_n    <= 1'b1;
        page_open <= 1'b0;
      end else if (take && i_write) begin
        o_oe_n    <= 1'b1;  // oe up first
        o_ce_n    <= 1'b0;
        page_open <= 1'b0;
      end else if (take && !page_hit) begin
        o_ce_n <= 1'b0;  // write strobe still high
        o_oe_n <= 1'b1;
      end else if (state == ST_READ_SETUP) begin
        o_oe_n <= 1'b0;
      end else if (state == ST_WRITE_LOW) begin
        o_we_n <= !o_oe_n;  // strobe low only with oe high
      end else if (state == ST_WRITE_HIGH) begin
        o_we_n <= 1'b1;  // device takes the data on this rise
        // select rises a cycle later so data hold is met
        if (cnt >= `CNT_W'(`WRITE_HIGH_CYC))
          o_ce_n <= 1'b1;  // back to standby
      end else if (state == ST_READ_WAIT &&
                   cnt >= wait_cyc_hold) begin
        page_open <= 1'b1;
      end
    end
  end

  // address and data stay put for the whole transfer
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      o_address_lines <= '0;
      o_data_lines    <= '0;
      o_data_lines_oe <= 1'b0;
    end else begin
      if (take) begin
        o_address_lines <= i_addr;
        o_data_lines    <= i_wdata;
      end
      o_data_lines_oe <= (take && i_write) ||
                         (o_data_lines_oe &&
                          (state == ST_WRITE_LOW ||
                           (state == ST_WRITE_HIGH && cnt == '0)));
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      o_rvalid <= 1'b0;
      o_rdata  <= '0;
    end else begin
      o_rvalid <= (state == ST_READ_WAIT) && (cnt >= wait_cyc_hold) &&
                  !i_flash_reset;
      if (state == ST_READ_WAIT && cnt >= wait_cyc_hold)
        o_rdata <= i_dq;
    end
  end

  AST_OE_WE_EXCL: assert property (!(!o_oe_n && !o_we_n))
    else $error("oe and we low together");
  AST_CE_IN_RESET: assert property (!o_reset_n |-> o_ce_n)
    else $error("select low in reset");
  AST_RESET_WIDTH: assert property (
    $fell(o_reset_n) && !i_flash_reset |-> !o_reset_n [*4])
    else $error("reset pulse short");
  AST_BUSY_BLOCK: assert property (
    !i_ready_busy_n && state == ST_IDLE && !i_flash_reset |=>
    state == ST_IDLE)
    else $error("transfer started while busy");
  AST_WE_OE_HIGH: assert property ($fell(o_we_n) |-> $past(o_oe_n))
    else $error("we fell, oe low");
  AST_READ_SETUP: assert property (
    $fell(o_oe_n) |-> $past(!o_ce_n) && o_we_n)
    else $error("oe fell without select");
  AST_CE_FALL_WE: assert property ($fell(o_ce_n) |-> o_we_n)
    else $error("select fell with we low");
  AST_ADDR_STABLE: assert property (
    !o_we_n |-> $stable(o_address_lines) && $stable(o_data_lines))
    else $error("bus moved in write");
  COV_READ: cover property (o_rvalid);
  COV_PAGE_HIT: cover property (take && page_hit);
  COV_WRITE: cover property ($rose(o_we_n));
  COV_RESET: cover property ($rose(o_reset_n));
endmodule : flash_host_ctrl

// [test/flash_dev_model.sv]
// Purpose: behavioural nor flash facing the host controller pins
// Assumes: pins from flash_host_ctrl; read data is a mix of the address
// Notes:   busy time is a plain default
`timescale 1ns/10ps
`include "flash_host_consts.svh"
module flash_dev_model #(
  parameter int BUSY_NS = 2000
) (
  input  wire logic               i_reset_n,
  input  wire logic               i_ce_n,
  input  wire logic               i_oe_n,
  input  wire logic               i_we_n,
  input  wire logic [`ADDR_W-1:0] i_address_lines,
  input  wire logic [`DATA_W-1:0] i_data_lines,
  output logic [`DATA_W-1:0]      o_dq,
  output logic                    o_ready_busy_n,
  output logic [`ADDR_W-1:0]      o_wr_addr,
  output logic [`DATA_W-1:0]      o_wr_data
);
  logic               drive;
  logic [`DATA_W-1:0] rd;
  logic [`DATA_W-1:0] last = '0;
  // select ignored while reset is low
  assign drive = i_reset_n && !i_ce_n && !i_oe_n && i_we_n;
  // new address gives new data
  assign rd = i_address_lines[15:0] ^ {i_address_lines[25:16], 6'h2A};
  // no pull on data lines: released bus shows the inverse
  // last word kept latched while outputs are off
  always @(drive or rd) if (drive) last = rd;
  assign o_dq = drive ? rd : ~last;
  // busy comes from the algorithm side only
  initial begin
    o_ready_busy_n = 1'b1;
    forever begin
      @(posedge i_we_n);
      if (i_reset_n && !i_ce_n) begin
        o_wr_addr = i_address_lines;
        o_wr_data = i_data_lines;
        o_ready_busy_n = 1'b0;
        #(BUSY_NS) o_ready_busy_n = 1'b1;
      end
    end
  end
endmodule : flash_dev_model

// [test/flash_host_ctrl_bench.sv]
// Purpose: self-checking bench for the flash host controller
// Assumes: device model in flash_dev_model
// Notes:   reset hold runs its full 1000 cycles
`timescale 1ns/10ps
`include "flash_host_consts.svh"
module flash_host_ctrl_bench;
  logic               i_mclk, i_reset, i_req, i_write, i_flash_reset;
  logic               o_ready, o_rvalid, o_reset_n, o_ce_n, o_oe_n, o_we_n;
  logic               o_data_lines_oe, ready_busy_n;
  logic [`ADDR_W-1:0] i_addr, o_address_lines, wr_addr;
  logic [`DATA_W-1:0] i_wdata, o_rdata, o_data_lines, flash_dq, dq, wr_data;
  int                 fails, tests_run;
  assign dq = o_data_lines_oe ? o_data_lines : flash_dq;
  flash_host_ctrl uut (.i_mclk(i_mclk), .i_reset(i_reset), .i_req(i_req),
    .i_write(i_write), .i_flash_reset(i_flash_reset), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_dq(dq), .i_ready_busy_n(ready_busy_n),
    .o_ready(o_ready), .o_rvalid(o_rvalid), .o_rdata(o_rdata),
    .o_reset_n(o_reset_n), .o_ce_n(o_ce_n), .o_oe_n(o_oe_n), .o_we_n(o_we_n),
    .o_address_lines(o_address_lines), .o_data_lines(o_data_lines),
    .o_data_lines_oe(o_data_lines_oe));
  flash_dev_model dev (.i_reset_n(o_reset_n), .i_ce_n(o_ce_n),
    .i_oe_n(o_oe_n), .i_we_n(o_we_n), .i_address_lines(o_address_lines),
    .i_data_lines(dq), .o_dq(flash_dq), .o_ready_busy_n(ready_busy_n),
    .o_wr_addr(wr_addr), .o_wr_data(wr_data));
  initial begin
    i_mclk = 1'b0;
    forever #25 i_mclk = ~i_mclk;
  end
  task automatic summarize;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : summarize
  task automatic check_data(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_data
  task automatic check_bit(input logic got, input logic exp);
    check_data({15'h0000, got}, {15'h0000, exp});
  endtask : check_bit
  task automatic step;
    @(posedge i_mclk);
    #1;
  endtask : step
  task automatic bail(input int n, input int lim);
    if (n > lim) begin
      fails++;
      summarize();
    end
  endtask : bail
  task automatic wait_ready(input int lim);
    int n;
    n = 0;
    while (o_ready !== 1'b1) begin
      if (o_reset_n === 1'b0) check_bit(o_ce_n, 1'b1);
      if (ready_busy_n === 1'b0) check_bit(o_ready, 1'b0);
      step();
      n++;
      bail(n, lim);
    end
  endtask : wait_ready
  task automatic request(input logic wr, input logic [25:0] a,
                         input logic [15:0] d);
    i_write = wr;
    i_addr = a;
    i_wdata = d;
    i_req = 1'b1;
    wait_ready(60);
    step();
    i_req = 1'b0;
  endtask : request
  task automatic read_chk(input logic [25:0] a);
    int n;
    n = 0;
    request(1'b0, a, 16'h0000);
    while (o_rvalid !== 1'b1) begin
      step();
      check_bit(o_oe_n | o_we_n, 1'b1);
      n++;
      bail(n, 40);
    end
    check_data(o_rdata, a[15:0] ^ {a[25:16], 6'h2A});
  endtask : read_chk
  task automatic sc_reads;
    read_chk(26'h00012A5);
    read_chk(26'h00012AC);
    read_chk(26'h3F012AC);
    read_chk(26'h3F012A0);
  endtask : sc_reads
  task automatic sc_write;
    request(1'b1, 26'h0155AAA, 16'hBEEF);
    repeat (6) step();
    check_bit(o_ready, 1'b0);
    wait_ready(200);
    check_data(wr_data, 16'hBEEF);
    check_data(wr_addr[15:0], 16'h5AAA);
    check_data({6'h00, wr_addr[25:16]}, 16'h0015);
    read_chk(26'h0155AA1);
  endtask : sc_write
  task automatic sc_abort;
    int n;
    n = 0;
    request(1'b0, 26'h2000033, 16'h0000);
    i_flash_reset = 1'b1;
    step();
    i_flash_reset = 1'b0;
    while (o_reset_n !== 1'b0) begin
      step();
      n++;
      bail(n, 5);
    end
    check_bit(o_ce_n, 1'b1);
    wait_ready(1100);
    read_chk(26'h2000033);
  endtask : sc_abort
  initial begin
    {i_req, i_write, i_flash_reset} = 3'b000;
    i_addr = 26'h0000000;
    i_wdata = 16'h0000;
    fails = 0;
    tests_run = 0;
    i_reset = 1'b1;
    repeat (2) step();
    check_bit(o_reset_n, 1'b0);
    i_reset = 1'b0;
    wait_ready(1100);
    sc_reads();
    sc_write();
    sc_abort();
    summarize();
  end
endmodule : flash_host_ctrl_bench
